// *** hw/lsco_pkg.sv ***
// constants and types of the line-sensor clock output control block
// Summary of operation
// - three or six states per conversion cycle
// - sync mode: continuous, trigger edge, or none
// - alignment loads the state phase delay
// - bank one enable opens bank one access
// - bank zero enable opens bank zero access
// - clock pattern enable opens pattern programming
// - clock polarity bits invert each clock line
// - group A fixed level one and two
// - group B fixed level one and two
// - first four group B lines OR shift pulses
// - first four group A lines OR shift pulses
// - invert clamp, white marker, line start
// - port3 polarity inverts black marker, and line start from patterns
// - invert each shift pulse output
// - pin select: clock or port, reset port
// - capture start bit enters image capture
// - line start external or from patterns
package lsco_pkg;
   // *****************************************************
   // register offsets
   // *****************************************************
   localparam logic [6:0] OFS_TG_CONTROL    = 7'h50;
   localparam logic [6:0] OFS_TG_MODE       = 7'h51;
   localparam logic [6:0] OFS_STATE_CONTROL = 7'h52;
   localparam logic [6:0] OFS_PATTERN_EN    = 7'h53;
   localparam logic [6:0] OFS_CLK_POLARITY  = 7'h54;
   localparam logic [6:0] OFS_GROUP_A_FIX   = 7'h55;
   localparam logic [6:0] OFS_GROUP_B_FIX   = 7'h56;
   localparam logic [6:0] OFS_OR_SELECT     = 7'h57;
   localparam logic [6:0] OFS_OUT_POLARITY  = 7'h58;
   localparam logic [6:0] OFS_PIN_SELECT    = 7'h59;
   localparam int         NUM_REGS          = 10;
   // *****************************************************
   // writable bits and reset values, in offset order
   // *****************************************************
   localparam logic [15:0] REG_MASK [0:NUM_REGS-1] = '{
      16'h0001, 16'h0100, 16'h01cf, 16'h0007, 16'h1f1f,
      16'h1f1f, 16'h1f1f, 16'h0f0f, 16'hf1ff, 16'h1f1f};
   localparam logic [15:0] REG_RESET [0:NUM_REGS-1] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1f1f};
   // *****************************************************
   // field positions
   // *****************************************************
   localparam int BIT_CAPTURE_START = 0;
   localparam int BIT_LINE_EXT_SEL  = 8;
   localparam int BIT_STATES_SEL    = 8;
   localparam int LSB_SYNC_MODE     = 6;
   localparam int LSB_PHASE_DELAY   = 0;
   localparam int BIT_CLK_PAT_EN    = 0;
   localparam int BIT_BANK0_EN      = 1;
   localparam int BIT_BANK1_EN      = 2;
   localparam int BIT_CLAMP_POL     = 15;
   localparam int BIT_WHITE_POL     = 14;
   localparam int BIT_LINE_POL      = 13;
   localparam int BIT_PORT3_POL     = 12;
   // *****************************************************
   // state counts and serial frame
   // *****************************************************
   localparam logic [2:0] STATES_THREE = 3'h3;
   localparam logic [2:0] STATES_SIX   = 3'h6;
   localparam logic [4:0] HDR_LAST_BIT = 5'h07;
   localparam logic [4:0] FRAME_LAST   = 5'h17;
   localparam logic [4:0] FRAME_BITS   = 5'h18;
   typedef enum logic [1:0] {
      LSCO_SYNC_CONT = 2'b00,
      LSCO_SYNC_OFF1 = 2'b01,
      LSCO_SYNC_TRIG = 2'b10,
      LSCO_SYNC_NONE = 2'b11
   } lsco_sync_e;
endpackage

// *** hw/lsco_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module lsco_pin_sync
   import lsco_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // pins and filtered levels
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         level <= '0;
      end else begin
         // a bit moves only where the last two stages agree
         level <= (level & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
      end
   end
endmodule
`default_nettype wire

// *** hw/lsco_state_seq.sv ***
// internal state sequencer with alignment modes and phase delay
`timescale 1ns/1ps
`default_nettype none
module lsco_state_seq
   import lsco_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // alignment events
   input  wire logic       ref_rise,
   input  wire logic       trig_rise,
   // configuration
   input  wire logic       six_states,
   input  wire logic [1:0] sync_mode,
   input  wire logic [3:0] phase_delay,
   // state
   output logic      [2:0] state_index,
   output logic            cycle_start
);
   logic [2:0] last_state;
   logic       align;
   logic [2:0] next_state;
   assign last_state = (six_states ? STATES_SIX : STATES_THREE) - 3'h1;
   always_comb begin
      unique case (lsco_sync_e'(sync_mode))
         LSCO_SYNC_CONT: align = ref_rise;
         LSCO_SYNC_TRIG: align = trig_rise;
         LSCO_SYNC_OFF1: align = 1'b0;
         LSCO_SYNC_NONE: align = 1'b0;
      endcase
      // out-of-range delays fall back to state zero
      if (align && ({1'b0, last_state} >= phase_delay)) begin
         next_state = phase_delay[2:0];
      end else if (align || (state_index >= last_state)) begin
         next_state = 3'h0;
      end else begin
         next_state = state_index + 3'h1;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_index <= 3'h0;
      end else begin
         state_index <= next_state;
      end
   end
   assign cycle_start = (state_index == 3'h0);
   // *****************************************************
   // assertions
   // *****************************************************
   a_three_states: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !six_states [*2] |-> state_index <= 3'h2)
      else $error("state beyond three-state range");
   a_state_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!align && state_index == last_state) |=> state_index == 3'h0)
      else $error("state did not wrap");
   a_sync_cont: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (sync_mode == 2'b00 && ref_rise && phase_delay <= 4'h2)
      |=> state_index == $past(phase_delay[2:0]))
      else $error("continuous alignment missed");
   a_sync_trig: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (sync_mode == 2'b10 && trig_rise && phase_delay == 4'h1)
      |=> state_index == 3'h1)
      else $error("trigger alignment missed");
   a_sync_none: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (sync_mode[0] && state_index == 3'h0) |=> state_index == 3'h1)
      else $error("alignment while disabled");
   c_six_wrap: cover property (@(posedge ref_clk) disable iff (!rst_n)
      six_states && state_index == 3'h5 ##1 state_index == 3'h0);
   c_trig_align: cover property (@(posedge ref_clk) disable iff (!rst_n)
      sync_mode == 2'b10 && trig_rise);
endmodule
`default_nettype wire

// *** hw/lsco_ctrl.sv ***
// register bank, serial host port and sensor clock output path
`timescale 1ns/1ps
`default_nettype none
module lsco_ctrl
   import lsco_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // serial host port
   input  wire logic       host_cs_n,
   input  wire logic       host_sclk,
   input  wire logic       host_sdi,
   output logic            host_sdo,
   output logic            host_sdo_oe,
   // timing inputs from pins
   input  wire logic       conversion_ref_clock,
   input  wire logic       shift_trigger_input,
   input  wire logic       line_start_ext_in,
   // pattern engine signals
   input  wire logic [9:0] clock_pattern,
   input  wire logic [9:0] fixed_one_sel,
   input  wire logic [9:0] fixed_two_sel,
   input  wire logic [8:0] shift_pattern,
   input  wire logic       clamp_pattern,
   input  wire logic       white_pattern,
   input  wire logic       line_start_pattern,
   input  wire logic       black_pattern,
   // general-purpose port drive for clock pins
   input  wire logic [9:0] port_data,
   // state and mode
   output logic      [2:0] state_index,
   output logic            cycle_start,
   output logic            capture_mode,
   output logic            bank1_access_en,
   output logic            bank0_access_en,
   output logic            clock_pattern_access_en,
   output logic      [9:0] pin_port_select,
   // driven outputs
   output logic      [9:0] clock_pin_out,
   output logic      [8:0] shift_pulse_out,
   output logic            clamp_timing_out,
   output logic            white_pixel_marker,
   output logic            line_start_signal,
   output logic            optical_black_marker
);
   // *****************************************************
   // pin synchronisers and edges
   // *****************************************************
   logic [5:0]  pins_f;
   logic        cs_n_f;
   logic        sclk_f;
   logic        sdi_f;
   logic        ref_f;
   logic        trig_f;
   logic        line_ext_f;
   logic        sclk_q;
   logic        ref_q;
   logic        trig_q;
   logic        sclk_rise;
   logic        sclk_fall;
   lsco_pin_sync #(.WIDTH(6)) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_in  ({line_start_ext_in, shift_trigger_input,
                 conversion_ref_clock, host_sdi, host_sclk, host_cs_n}),
      .level   (pins_f)
   );
   assign cs_n_f     = pins_f[0];
   assign sclk_f     = pins_f[1];
   assign sdi_f      = pins_f[2];
   assign ref_f      = pins_f[3];
   assign trig_f     = pins_f[4];
   assign line_ext_f = pins_f[5];
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q <= 1'b0;
         ref_q  <= 1'b0;
         trig_q <= 1'b0;
      end else begin
         sclk_q <= sclk_f;
         ref_q  <= ref_f;
         trig_q <= trig_f;
      end
   end
   assign sclk_rise = sclk_f & ~sclk_q & ~cs_n_f;
   assign sclk_fall = ~sclk_f & sclk_q & ~cs_n_f;
   // *****************************************************
   // address decode
   // *****************************************************
   function automatic logic [4:0] decode(input logic [6:0] a);
      logic [4:0] r;
      r = 5'h00;
      case (a)
         OFS_TG_CONTROL:    r = 5'h10;
         OFS_TG_MODE:       r = 5'h11;
         OFS_STATE_CONTROL: r = 5'h12;
         OFS_PATTERN_EN:    r = 5'h13;
         OFS_CLK_POLARITY:  r = 5'h14;
         OFS_GROUP_A_FIX:   r = 5'h15;
         OFS_GROUP_B_FIX:   r = 5'h16;
         OFS_OR_SELECT:     r = 5'h17;
         OFS_OUT_POLARITY:  r = 5'h18;
         OFS_PIN_SELECT:    r = 5'h19;
         default:           r = 5'h00;
      endcase
      return r;
   endfunction
   // *****************************************************
   // serial frame: read flag, 7-bit address, 16-bit data
   // *****************************************************
   logic [4:0]  bit_cnt;
   logic [22:0] shift_in;
   logic [6:0]  frame_addr;
   logic        frame_read;
   logic [15:0] shift_out;
   logic [15:0] regs [0:NUM_REGS-1];
   logic [4:0]  hdr_dec;
   logic [4:0]  wr_dec;
   logic        wr_commit;
   logic [15:0] wr_data;
   assign hdr_dec   = decode({shift_in[5:0], sdi_f});
   assign wr_dec    = decode(frame_addr);
   assign wr_commit = sclk_rise && bit_cnt == FRAME_LAST && !frame_read;
   assign wr_data   = {shift_in[14:0], sdi_f};
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt  <= 5'h00;
         shift_in <= 23'h000000;
      end else if (cs_n_f) begin
         bit_cnt <= 5'h00;
      end else if (sclk_rise && bit_cnt < FRAME_BITS) begin
         bit_cnt  <= bit_cnt + 5'h01;
         shift_in <= {shift_in[21:0], sdi_f};
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_addr <= 7'h00;
         frame_read <= 1'b0;
      end else if (cs_n_f) begin
         frame_read <= 1'b0;
      end else if (sclk_rise && bit_cnt == HDR_LAST_BIT) begin
         frame_addr <= {shift_in[5:0], sdi_f};
         frame_read <= shift_in[6];
      end
   end
   // read data loads at the header's last edge, shifts after each sample
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_out <= 16'h0000;
      end else if (sclk_rise && bit_cnt == HDR_LAST_BIT) begin
         shift_out <= hdr_dec[4] ? regs[hdr_dec[3:0]] : 16'h0000;
      end else if (sclk_fall && bit_cnt > 5'h08) begin
         shift_out <= {shift_out[14:0], 1'b0};
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         host_sdo_oe <= 1'b0;
      end else begin
         host_sdo_oe <= !cs_n_f && frame_read && bit_cnt >= 5'h08;
      end
   end
   assign host_sdo = shift_out[15];
   // *****************************************************
   // register bank
   // *****************************************************
   genvar r;
   for (r = 0; r < NUM_REGS; r++) begin : g_reg
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            regs[r] <= REG_RESET[r];
         end else if (wr_commit && wr_dec == (5'h10 + 5'(r))) begin
            regs[r] <= wr_data & REG_MASK[r];
         end
      end
   end
   logic [15:0] st_ctl;
   logic [15:0] pol;
   logic        line_ext_sel;
   assign st_ctl       = regs[2];
   assign pol          = regs[8];
   assign line_ext_sel = regs[1][BIT_LINE_EXT_SEL];
   assign capture_mode            = regs[0][BIT_CAPTURE_START];
   assign bank1_access_en         = regs[3][BIT_BANK1_EN];
   assign bank0_access_en         = regs[3][BIT_BANK0_EN];
   assign clock_pattern_access_en = regs[3][BIT_CLK_PAT_EN];
   assign pin_port_select         = {regs[9][12:8], regs[9][4:0]};
   // *****************************************************
   // internal state sequencer
   // *****************************************************
   lsco_state_seq u_seq (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .ref_rise    (ref_f & ~ref_q),
      .trig_rise   (trig_f & ~trig_q),
      .six_states  (st_ctl[BIT_STATES_SEL]),
      .sync_mode   (st_ctl[LSB_SYNC_MODE+:2]),
      .phase_delay (st_ctl[LSB_PHASE_DELAY+:4]),
      .state_index (state_index),
      .cycle_start (cycle_start)
   );
   // *****************************************************
   // clock output path: level, OR, polarity, pin mux
   // *****************************************************
   logic [9:0] lv_one;
   logic [9:0] lv_two;
   logic [9:0] or_sel;
   logic [9:0] clk_inv;
   logic [9:0] next_clock;
   logic [9:0] clk_func;
   logic       line_src;
   logic       line_inv;
   assign lv_one  = {regs[6][4:0], regs[5][4:0]};
   assign lv_two  = {regs[6][12:8], regs[5][12:8]};
   assign or_sel  = {1'b0, regs[7][11:8], 1'b0, regs[7][3:0]};
   assign clk_inv = {regs[4][12:8], regs[4][4:0]};
   genvar c;
   for (c = 0; c < 10; c++) begin : g_clk
      logic base;
      logic shift_or;
      assign base = fixed_two_sel[c] ? lv_two[c] :
                    fixed_one_sel[c] ? lv_one[c] : clock_pattern[c];
      // lines a..d and 1..4 merge shift pulses 6..9
      assign shift_or = or_sel[c] & shift_pattern[5 + (c % 5)];
      assign clk_func[c]   = (base | shift_or) ^ clk_inv[c];
      assign next_clock[c] = pin_port_select[c] ? port_data[c]
                                                : clk_func[c];
   end
   assign line_src = line_ext_sel ? line_ext_f : line_start_pattern;
   assign line_inv = pol[BIT_LINE_POL] ^ (pol[BIT_PORT3_POL] & ~line_ext_sel);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clock_pin_out        <= 10'h000;
         shift_pulse_out      <= 9'h000;
         clamp_timing_out     <= 1'b0;
         white_pixel_marker   <= 1'b0;
         line_start_signal    <= 1'b0;
         optical_black_marker <= 1'b0;
      end else begin
         clock_pin_out        <= next_clock;
         shift_pulse_out      <= shift_pattern ^ pol[8:0];
         clamp_timing_out     <= clamp_pattern ^ pol[BIT_CLAMP_POL];
         white_pixel_marker   <= white_pattern ^ pol[BIT_WHITE_POL];
         line_start_signal    <= line_src ^ line_inv;
         optical_black_marker <= black_pattern ^ pol[BIT_PORT3_POL];
      end
   end
   // *****************************************************
   // assertions
   // *****************************************************
   a_pin_reset_port: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> pin_port_select == 10'h3ff)
      else $error("pins not general-purpose after reset");
   a_clock_path: assert property (@(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> clock_pin_out == $past(next_clock))
      else $error("clock pin output mismatch");
   a_group_a_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (regs[7][0] && shift_pattern[5] && !pin_port_select[0] && !clk_inv[0])
      |=> clock_pin_out[0])
      else $error("group A OR with shift pulse 6 missing");
   a_group_b_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (regs[7][11] && shift_pattern[8] && !pin_port_select[8] && !clk_inv[8])
      |=> clock_pin_out[8])
      else $error("group B OR with shift pulse 9 missing");
   a_fixed_two: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (fixed_two_sel[1] && !pin_port_select[1] && !clk_inv[1])
      |=> clock_pin_out[1] == $past(lv_two[1] | (or_sel[1] & shift_pattern[6])))
      else $error("fixed level two not driven");
   a_shift_invert: assert property (@(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> shift_pulse_out == ($past(shift_pattern) ^ $past(regs[8][8:0])))
      else $error("shift pulse polarity wrong");
   a_clamp_invert: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(regs[8][15]) && $past(clamp_pattern) |-> !clamp_timing_out)
      else $error("clamp not inverted");
   a_line_ext: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (line_ext_sel && !pol[13]) |=> line_start_signal == $past(line_ext_f))
      else $error("external line start not followed");
   a_write_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_commit && wr_dec == 5'h13) |=> regs[3] == ($past(wr_data) & 16'h0007))
      else $error("access enable write not stored");
   a_access_en: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_commit && wr_dec == 5'h13) |=> bank0_access_en == $past(wr_data[1]))
      else $error("bank zero enable not applied");
   a_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_commit && wr_dec == 5'h10) |=> capture_mode == $past(wr_data[0]))
      else $error("capture start not applied");
   a_port_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pin_port_select[3] |=> clock_pin_out[3] == $past(port_data[3]))
      else $error("port data not on pin");
   a_sdo_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !frame_read |=> !host_sdo_oe)
      else $error("serial output driven outside a read");
   c_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
      wr_commit && wr_dec == 5'h19);
   c_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
      host_sdo_oe && host_sdo);
   c_clock_func: cover property (@(posedge ref_clk) disable iff (!rst_n)
      !pin_port_select[0] && clk_func[0]);
endmodule
`default_nettype wire

// *** tb/lsco_afe_model.sv ***
// conversion reference clock source in place of the analog front end
`timescale 1ns/1ps
`default_nettype none
module lsco_afe_model #(
   parameter int HALF = 3
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // clock toward the device pin
   output logic      conversion_ref_clock
);
   int cnt;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         conversion_ref_clock <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         conversion_ref_clock <= ~conversion_ref_clock;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire

// *** tb/test_line_sensor_clock_output_ctrl.sv ***
// bench for the sensor clock output control block over its serial port
`timescale 1ns/1ps
`default_nettype none
module test_line_sensor_clock_output_ctrl;
   import lsco_pkg::*;
   logic            ref_clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, sclk = 1'b0;
   logic            sdi = 1'b0, trig = 1'b0, ext = 1'b0, clp = 1'b0;
   logic            whp = 1'b0, lsp = 1'b0, obp = 1'b0;
   logic [9:0]      pat = '0, fx1 = '0, fx2 = '0, pdat = '0;
   logic [8:0]      sh = '0;
   wire logic       sdo, oe, refc, cst, cap, b1, b0, cpe, clo, wmo, lso, obo;
   wire logic [2:0] st;
   wire logic [9:0] psel, cko;
   wire logic [8:0] sho;
   int              fail_count = 0, check_count = 0, cyc = 0;
   always #5 ref_clk = ~ref_clk;
   lsco_afe_model afe_u (.ref_clk(ref_clk), .rst_n(rst_n),
      .conversion_ref_clock(refc));
   lsco_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .host_cs_n(cs_n),
      .host_sclk(sclk), .host_sdi(sdi), .host_sdo(sdo), .host_sdo_oe(oe),
      .conversion_ref_clock(refc), .shift_trigger_input(trig),
      .line_start_ext_in(ext), .clock_pattern(pat), .fixed_one_sel(fx1),
      .fixed_two_sel(fx2), .shift_pattern(sh), .clamp_pattern(clp),
      .white_pattern(whp), .line_start_pattern(lsp), .black_pattern(obp),
      .port_data(pdat), .state_index(st), .cycle_start(cst),
      .capture_mode(cap), .bank1_access_en(b1), .bank0_access_en(b0),
      .clock_pattern_access_en(cpe), .pin_port_select(psel),
      .clock_pin_out(cko), .shift_pulse_out(sho), .clamp_timing_out(clo),
      .white_pixel_marker(wmo), .line_start_signal(lso),
      .optical_black_marker(obo));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         tally_and_finish;
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic look(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   // 24-bit frame: read flag, address, data, each level held 8 clocks
   task automatic xfer(input logic rd, input logic [6:0] a,
                       input logic [15:0] wd, output logic [15:0] q);
      logic [23:0] f;
      f = {rd, a, wd};
      q = '0;
      @(posedge ref_clk);
      cs_n <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdi  <= f[i];
         sclk <= 1'b0;
         repeat (8) @(posedge ref_clk);
         if (i < 16) q = {q[14:0], sdo};
         if (i == 0) chk(16'(oe), 16'(rd));
         sclk <= 1'b1;
         repeat (8) @(posedge ref_clk);
      end
      sclk <= 1'b0;
      cs_n <= 1'b1;
      look(6);
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] q;
      xfer(1'b0, a, d, q);
   endtask
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      logic [15:0] q;
      xfer(1'b1, a, 16'h0000, q);
      chk(q, e);
   endtask
   task automatic t_regs;
      chk(16'(psel), 16'h03ff);
      for (int k = 2; k < NUM_REGS; k++) begin
         rd(7'(k + 'h50), REG_RESET[k]);
      end
      for (int k = 4; k < NUM_REGS; k++) begin
         wr(7'(k + 'h50), 16'hffff);
         rd(7'(k + 'h50), REG_MASK[k]);
         wr(7'(k + 'h50), 16'h0000);
      end
      chk(16'(psel), 16'h0000);
      wr(7'h60, 16'hffff);
      rd(7'h60, 16'h0000);
      $display("registers done");
   endtask
   task automatic t_access;
      for (int b = 0; b < 3; b++) begin
         wr(OFS_PATTERN_EN, 16'(1 << b));
         chk({13'h0, b1, b0, cpe}, 16'(1 << b));
         wr(OFS_PATTERN_EN, 16'h0000);
      end
      chk({13'h0, b1, b0, cpe}, 16'h0000);
      wr(OFS_TG_CONTROL, 16'h0001);
      chk(16'(cap), 16'h0001);
      wr(OFS_TG_CONTROL, 16'h0000);
      chk(16'(cap), 16'h0000);
      $display("access done");
   endtask
   task automatic t_out;
      @(posedge ref_clk);
      pat <= 10'h2a5;
      look(3);
      chk(16'(cko), 16'h02a5);
      wr(OFS_CLK_POLARITY, 16'h0a05);
      chk(16'(cko), 16'h03e0);
      wr(OFS_GROUP_A_FIX, 16'h1305);
      wr(OFS_GROUP_B_FIX, 16'h0c1a);
      @(posedge ref_clk);
      fx1 <= 10'h3ff;
      look(3);
      chk(16'(cko), 16'h0200);
      @(posedge ref_clk);
      fx2 <= 10'h3ff;
      look(3);
      chk(16'(cko), 16'h00d6);
      wr(OFS_CLK_POLARITY, 16'h0000);
      wr(OFS_OR_SELECT, 16'h0f0f);
      wr(OFS_OUT_POLARITY, 16'h01ff);
      @(posedge ref_clk);
      fx1 <= '0;
      fx2 <= '0;
      pat <= '0;
      sh  <= 9'h1e0;
      look(3);
      chk(16'(cko), 16'h01ef);
      chk(16'(sho), 16'h001f);
      wr(OFS_OR_SELECT, 16'h0000);
      chk(16'(cko), 16'h0000);
      wr(OFS_PIN_SELECT, 16'h1f1f);
      @(posedge ref_clk);
      pdat <= 10'h155;
      look(3);
      chk(16'(cko), 16'h0155);
      $display("outputs done");
   endtask
   task automatic t_marks;
      wr(OFS_OUT_POLARITY, 16'h8000);
      @(posedge ref_clk);
      clp <= 1'b1;
      lsp <= 1'b1;
      look(3);
      chk({clo, wmo, lso, obo}, 16'h0002);
      wr(OFS_OUT_POLARITY, 16'h7000);
      chk({clo, wmo, lso, obo}, 16'h000f);
      wr(OFS_OUT_POLARITY, 16'h1000);
      chk({clo, wmo, lso, obo}, 16'h0009);
      wr(OFS_TG_MODE, 16'h0100);
      @(posedge ref_clk);
      ext <= 1'b1;
      look(8);
      chk({clo, wmo, lso, obo}, 16'h000b);
      $display("markers done");
   endtask
   task automatic period(input logic [15:0] v, input int n);
      int c;
      wr(OFS_STATE_CONTROL, v);
      c = 0;
      while (cst !== 1'b1 && c < 20) begin
         @(negedge ref_clk);
         c++;
      end
      c = 0;
      do begin
         @(negedge ref_clk);
         c++;
      end while (cst !== 1'b1 && c < 20);
      chk(16'(c), 16'(n));
   endtask
   // state before a trigger pulse and eleven clocks after it starts
   task automatic trg(input logic [15:0] v, output logic [2:0] p,
                      output logic [2:0] s);
      wr(OFS_STATE_CONTROL, v);
      p = st;
      @(posedge ref_clk);
      trig <= 1'b1;
      repeat (6) @(posedge ref_clk);
      trig <= 1'b0;
      look(5);
      s = st;
   endtask
   task automatic t_sync;
      logic [2:0] p, a, b;
      period(16'h00c0, 3);
      period(16'h01c0, 6);
      trg(16'h0180, p, a);
      trg(16'h0183, p, b);
      chk(16'(b), 16'((a + 3) % 6));
      trg(16'h0143, p, b);
      chk(16'(b), 16'(p));
      trg(16'h01c3, p, b);
      chk(16'(b), 16'(p));
      wr(OFS_STATE_CONTROL, 16'h0002);
      @(posedge refc);
      look(5);
      chk(16'(st), 16'h0002);
      $display("sequencer done");
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      look(8);
      t_regs;
      t_access;
      t_out;
      t_marks;
      t_sync;
      tally_and_finish;
   end
endmodule
`default_nettype wire
